// ### bench/bmwa_partner.sv
// Far side model: a memory slave and an alternate bus master.
// Assumes the bench changes want, keep, ack_en and dly off the clock edge.
module bmwa_partner (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  dly,
  input  wire logic        want,
  input  wire logic        keep,
  input  wire logic        ack_en,
  input  wire logic        addr_valid_strobe,
  input  wire logic        upper_byte_strobe,
  input  wire logic        lower_byte_strobe,
  input  wire logic        write_not_read,
  input  wire logic [15:0] data_out,
  input  wire logic        mastership_grant,
  output logic             transfer_acknowledge,
  output logic [15:0]      data_in,
  output logic             mastership_request,
  output logic             grant_acknowledge,
  output logic [3:0]       tenures
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_r;
  logic [1:0]  wcnt_r;
  logic [4:0]  hold_r;
  logic        lanes;
  assign lanes = upper_byte_strobe | lower_byte_strobe;
  // Undriven data shows the inverse so a stale value never passes.
  assign data_in = (lanes && !write_not_read) ? mem_r : ~mem_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      transfer_acknowledge <= 1'b0;
      mastership_request <= 1'b0;
      grant_acknowledge <= 1'b0;
      wcnt_r <= 2'h0;
      hold_r <= 5'h0;
      tenures <= 4'h0;
      mem_r <= 16'h0;
    end else begin
      if (!lanes) wcnt_r <= 2'h0;
      else if (wcnt_r != dly) wcnt_r <= wcnt_r + 2'h1;
      transfer_acknowledge <= lanes && wcnt_r == dly;
      if (lanes && wcnt_r == dly && write_not_read && upper_byte_strobe)
        mem_r[15:8] <= data_out[15:8];
      if (lanes && wcnt_r == dly && write_not_read && lower_byte_strobe)
        mem_r[7:0] <= data_out[7:0];
      mastership_request <= want && !(grant_acknowledge && !keep);
      // take over only on a free bus.
      if (!grant_acknowledge && mastership_grant && want && ack_en &&
          !addr_valid_strobe && !transfer_acknowledge) begin
        grant_acknowledge <= 1'b1;
        hold_r <= 5'h14;
        tenures <= tenures + 4'h1;
      end else if (hold_r != 5'h0) hold_r <= hold_r - 5'h1;
      else grant_acknowledge <= 1'b0;
    end
  end
endmodule : bmwa_partner

// ### bench/bmwa_props.sv
// Port checker for bmwa_top, attached by bind.
// Assumes one sys_clk domain and synchronous active-low resetn.
module bmwa_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic mastership_request,
  input wire logic grant_acknowledge,
  input wire logic addr_valid_strobe,
  input wire logic upper_byte_strobe,
  input wire logic lower_byte_strobe,
  input wire logic write_not_read,
  input wire logic data_oe,
  input wire logic ctrl_oe,
  input wire logic mastership_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_lane;
    (upper_byte_strobe || lower_byte_strobe) |-> addr_valid_strobe;
  endproperty
  a_lane: assert property (p_lane)
    else $error("lane strobe without address strobe");
  property p_rmw;
    $rose(write_not_read) && $past(addr_valid_strobe)
      |-> !(upper_byte_strobe && lower_byte_strobe);
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("write-back used both lanes");
  property p_float;
    (grant_acknowledge[*5] ##0 !addr_valid_strobe) |-> !ctrl_oe && !data_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("buses driven while released");
  property p_ackdrop;
    $rose(grant_acknowledge) |-> ##[1:10] !mastership_grant;
  endproperty
  a_ackdrop: assert property (p_ackdrop)
    else $error("grant kept after acknowledge");
  property p_regrant;
    $fell(mastership_grant) && mastership_request && grant_acknowledge
      |-> ##[1:10] mastership_grant;
  endproperty
  a_regrant: assert property (p_regrant)
    else $error("pending request not granted again");
  property p_start;
    $rose(addr_valid_strobe) |-> !$past(mastership_grant);
  endproperty
  a_start: assert property (p_start)
    else $error("own cycle started while granting");
  property p_sync;
    $rose(mastership_request) && !mastership_grant |-> ##1 !mastership_grant;
  endproperty
  a_sync: assert property (p_sync)
    else $error("grant before request synchronised");
  property p_drop;
    (!mastership_request && !grant_acknowledge)[*8] |-> !mastership_grant;
  endproperty
  a_drop: assert property (p_drop)
    else $error("grant held after request withdrawn");
endmodule : bmwa_props

bind bmwa_top bmwa_props i_props (.sys_clk, .resetn, .mastership_request,
  .grant_acknowledge, .addr_valid_strobe, .upper_byte_strobe,
  .lower_byte_strobe, .write_not_read, .data_oe, .ctrl_oe,
  .mastership_grant);

// ### bench/bmwa_top_tb_top.sv
// Self-checking bench for bmwa_top with the far side model.
// Assumes bmwa_props is bound to the design by its own file.
module bmwa_top_tb_top
  import bmwa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, cyc_start, cyc_write, cyc_word, cyc_atomic;
  logic byte_select_bit, bus_fault_input, want, keep, ack_en, lane_p, avs_p;
  logic cyc_ready, cyc_done, data_oe, addr_valid_strobe, upper_byte_strobe;
  logic lower_byte_strobe, write_not_read, ctrl_oe, mastership_grant;
  logic mastership_request, grant_acknowledge, transfer_acknowledge;
  logic [15:0] cyc_wdata, data_in, data_out, cyc_rdata, mem_m, mem_s;
  logic [18:0] exp_q[$];
  logic [3:0]  tenures, t0;
  logic [2:0]  r;
  logic [1:0]  dly, flim;
  logic [7:0]  b;
  int num_errors, n_tests, falls, f0, i, k, fcnt;
  bmwa_top i_dut (.sys_clk, .resetn, .cyc_start, .cyc_write, .cyc_word,
    .cyc_atomic, .byte_select_bit, .cyc_wdata, .cyc_ready, .cyc_done,
    .cyc_rdata, .mastership_request, .grant_acknowledge,
    .transfer_acknowledge, .bus_fault_input, .data_in, .data_out, .data_oe,
    .addr_valid_strobe, .upper_byte_strobe, .lower_byte_strobe,
    .write_not_read, .ctrl_oe, .mastership_grant);
  bmwa_partner i_far (.sys_clk, .resetn, .dly, .want, .keep, .ack_en,
    .addr_valid_strobe, .upper_byte_strobe, .lower_byte_strobe,
    .write_not_read, .data_out, .mastership_grant, .transfer_acknowledge,
    .data_in, .mastership_request, .grant_acknowledge, .tenures);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic issue(input logic w, wd, at, sl, input logic [15:0] d);
    for (k = 0; k < 200 && cyc_ready !== 1'b1; k++) @(negedge sys_clk);
    {cyc_write, cyc_word, cyc_atomic, byte_select_bit} = {w, wd, at, sl};
    cyc_wdata = d;
    cyc_start = 1'b1;
    exp_q.push_back({w, wd && !at || !sl, wd && !at || sl, w ? d : 16'h0});
    if (w && (wd || !sl)) mem_m[15:8] = d[15:8];
    if (w && (wd || sl)) mem_m[7:0] = d[7:0];
    @(negedge sys_clk);
    cyc_start = 1'b0;
  endtask : issue
  task automatic fin(input logic rdw);
    for (k = 0; k < 300 && cyc_done !== 1'b1; k++) @(negedge sys_clk);
    chk(19'(cyc_done), 19'h1);
    if (rdw) chk(19'(cyc_rdata), 19'(mem_m));
  endtask : fin
  // Lane strobes are noted as each data phase opens.
  always @(negedge sys_clk) begin
    if (resetn && (upper_byte_strobe || lower_byte_strobe) && !lane_p)
      chk({write_not_read, upper_byte_strobe, lower_byte_strobe,
           write_not_read ? data_out : 16'h0}, exp_q.pop_front());
    if (resetn && !addr_valid_strobe && avs_p) falls++;
    lane_p = upper_byte_strobe || lower_byte_strobe;
    avs_p = addr_valid_strobe;
  end
  always @(negedge sys_clk) begin
    fcnt = addr_valid_strobe ? fcnt + 1 : 0;
    bus_fault_input = flim != 2'h0 && fcnt >= flim;
  end
  initial begin
    #300000;
    num_errors++;
    end_sim();
  end
  initial begin
    {resetn, cyc_start, cyc_write, cyc_word, cyc_atomic} = 5'h0;
    {byte_select_bit, flim, want, keep, ack_en} = 6'h0;
    {cyc_wdata, mem_m, dly, lane_p, avs_p} = 36'h0;
    void'($urandom(32'hc45de682));
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    for (i = 0; i < 16; i++) begin
      dly = 2'($urandom_range(3));
      b = 8'($urandom);
      r = 3'($urandom);
      issue(r[0], r[1], 1'b0, r[2], {b, b});
      fin(!r[0] && r[1]);
    end
    $display("random transfers done");
    for (i = 0; i < 2; i++) begin
      f0 = falls;
      b = 8'($urandom);
      issue(1'b0, 1'b1, 1'b1, i[0], 16'h0);
      @(negedge sys_clk);
      {cyc_write, cyc_wdata, cyc_start} = {1'b1, b, b, 1'b1};
      exp_q.push_back({1'b1, !i[0], i[0], b, b});
      for (k = 0; k < 100 && write_not_read !== 1'b1; k++)
        @(negedge sys_clk);
      cyc_start = 1'b0;
      fin(1'b1);
      chk(19'(falls - f0), 19'h1);
      mem_m[(i[0] ? 7 : 15) -: 8] = b;
    end
    issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
    fin(1'b1);
    $display("read-modify-write done");
    mem_s = mem_m;
    {flim, dly} = 4'hb;
    issue(1'b1, 1'b1, 1'b0, 1'b0, ~mem_m);
    mem_m = mem_s;
    fin(1'b0);
    flim = 2'h0;
    issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
    fin(1'b1);
    $display("bus fault done");
    {ack_en, dly} = 3'h7;
    issue(1'b1, 1'b1, 1'b0, 1'b0, 16'($urandom));
    want = 1'b1;
    fin(1'b0);
    for (k = 0; k < 100 && grant_acknowledge !== 1'b1; k++)
      @(negedge sys_clk);
    repeat (6) @(negedge sys_clk);
    chk(19'({ctrl_oe, data_oe, addr_valid_strobe}), 19'h0);
    want = 1'b0;
    repeat (30) @(negedge sys_clk);
    chk(19'(tenures), 19'h1);
    $display("handover done");
    {ack_en, want} = 2'h1;
    for (k = 0; k < 50 && mastership_grant !== 1'b1; k++) @(negedge sys_clk);
    chk(19'(mastership_grant), 19'h1);
    want = 1'b0;
    issue(1'b1, 1'b0, 1'b0, 1'b1, 16'h5a5a);
    fin(1'b0);
    $display("withdrawn request done");
    t0 = tenures;
    {ack_en, keep, want} = 3'h7;
    for (k = 0; k < 400 && tenures !== t0 + 4'h2; k++) @(negedge sys_clk);
    {keep, want} = 2'h0;
    repeat (40) @(negedge sys_clk);
    chk(19'(tenures - t0), 19'h2);
    issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
    fin(1'b1);
    $display("regrant done");
    chk(19'(exp_q.size()), 19'h0);
    end_sim();
  end
endmodule : bmwa_top_tb_top

// ### verilog/bmwa_pkg.sv
// Package for the bus master write and arbitration block.
// Assumes a single sys_clk domain; all constants shared by design and bench.
package bmwa_pkg;

  // Grant negate delay after acknowledge changes, in clock cycles.
  localparam logic [3:0] BMWA_GNT_NEG_DLY = 4'h2;
  // Grant reassert delay after negation, in clock cycles.
  localparam logic [3:0] BMWA_GNT_REA_DLY = 4'h2;
  // Reset value of active-high internal strobes and grant.
  localparam logic       BMWA_RST_OFF     = 1'b0;

  // Processor bus phases as seen by this block.
  typedef enum logic [2:0] {
    BMWA_BUS_IDLE,
    BMWA_BUS_S0,
    BMWA_BUS_S1,
    BMWA_BUS_ADDR,
    BMWA_BUS_DATA,
    BMWA_BUS_RMW_GAP,
    BMWA_BUS_END
  } bmwa_bus_t;

  // Arbitration states.
  typedef enum logic [2:0] {
    BMWA_ARB_OWN,
    BMWA_ARB_WAIT_S0,
    BMWA_ARB_GRANT,
    BMWA_ARB_ACKED,
    BMWA_ARB_NEG_WAIT,
    BMWA_ARB_REASSERT
  } bmwa_arb_t;

endpackage : bmwa_pkg

// ### verilog/bmwa_sync.sv
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to sys_clk.
module bmwa_sync
  import bmwa_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= BMWA_RST_OFF;
      sync_r <= BMWA_RST_OFF;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : bmwa_sync

// ### verilog/bmwa_top.sv
// Bus master write strobes, read-modify-write sequencing and arbitration.
// Assumes a core issues one-cycle cycle requests; the pins except resetn are active high.
// What this block does
// R01 - Word writes strobe upper and lower byte lanes together.
// R02 - Byte writes: select bit zero picks upper lane, one picks lower.
// R03 - Read-modify-write reads then writes same address, strobe held throughout.
// R04 - Read-modify-write cycles only for the atomic flag op, single byte.
// R05 - On request, release bus only after the started cycle ends.
// R06 - Requests are accepted while own transfers are in progress.
// R07 - Request withdrawn before acknowledge returns device to normal work.
// R08 - Grant asserted right after request synchronisation.
// R09 - Request in bus state zero delays grant to second edge.
// R10 - Other master waits for strobe, transfer ack and grant ack negated.
// R11 - Nobody takes the bus while the address strobe is asserted.
// R12 - Master owns the bus while it holds grant acknowledge.
// R13 - Granted master drops its request after acknowledging.
// R14 - Grant negates after acknowledge changes; reasserts soon if pending.
// R15 - No own bus cycle between grant negation and reassertion.
// R16 - Asynchronous inputs synchronised before internal use.
// R17 - Grant and three-state update on edge after synchronised inputs.
// R18 - Three-state control floats buses once address strobe negates.
// R19 - Arbitration holds state while bus is in state zero or one.
// R20 - External logic times the cycle and raises the bus fault input.
// R21 - Grant negate and reassert delays are fixed cycle counts.
module bmwa_top
  import bmwa_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        cyc_start,
  input  wire logic        cyc_write,
  input  wire logic        cyc_word,
  input  wire logic        cyc_atomic,
  input  wire logic        byte_select_bit,
  input  wire logic [15:0] cyc_wdata,
  output logic             cyc_ready,
  output logic             cyc_done,
  output logic [15:0]      cyc_rdata,
  input  wire logic        mastership_request,
  input  wire logic        grant_acknowledge,
  input  wire logic        transfer_acknowledge,
  input  wire logic        bus_fault_input,
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic             data_oe,
  output logic             addr_valid_strobe,
  output logic             upper_byte_strobe,
  output logic             lower_byte_strobe,
  output logic             write_not_read,
  output logic             ctrl_oe,
  output logic             mastership_grant
);

  logic        req_s, ack_s, transfer_acknowledge_s, fault_s;
  bmwa_bus_t   bus_r, bus_nxt;
  logic        wr_r, wr_nxt;
  logic        word_r, word_nxt;
  logic        sel_r, sel_nxt;
  logic        rmw_r, rmw_nxt;
  logic        rmw_wr_r, rmw_wr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        done_r, done_nxt;
  bmwa_arb_t   arb_r, arb_nxt;
  logic        gnt_r, gnt_nxt;
  logic        tri_r, tri_nxt;
  logic [3:0]  cnt_r, cnt_nxt;

  // R16 sync each input
  bmwa_sync u_sync_req (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (mastership_request),
    .sync_out (req_s)
  );
  bmwa_sync u_sync_ack (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (grant_acknowledge),
    .sync_out (ack_s)
  );
  bmwa_sync u_sync_transfer_acknowledge (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (transfer_acknowledge),
    .sync_out (transfer_acknowledge_s)
  );
  bmwa_sync u_sync_fault (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (bus_fault_input),
    .sync_out (fault_s)
  );

  // Byte lane choice shared by both strobes.
  function automatic logic [1:0] lanes(input logic word, input logic sel);
    // R01 both lanes word
    if (word) begin
      lanes = 2'h3;
    // R02 select bit lane
    end else if (!sel) begin
      lanes = 2'h2;
    end else begin
      lanes = 2'h1;
    end
  endfunction : lanes

  // R15 no own cycles
  assign cyc_ready = (bus_r == BMWA_BUS_IDLE) && !tri_r
                     && (arb_r == BMWA_ARB_OWN) && !req_s;

  always_comb begin
    bus_nxt    = bus_r;
    wr_nxt     = wr_r;
    word_nxt   = word_r;
    sel_nxt    = sel_r;
    rmw_nxt    = rmw_r;
    rmw_wr_nxt = rmw_wr_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    done_nxt   = 1'b0;
    case (bus_r)
      BMWA_BUS_IDLE: begin
        if (cyc_start && cyc_ready) begin
          bus_nxt    = BMWA_BUS_S0;
          // R04 atomic is byte
          rmw_nxt    = cyc_atomic;
          word_nxt   = cyc_word && !cyc_atomic;
          wr_nxt     = cyc_write && !cyc_atomic;
          sel_nxt    = byte_select_bit;
          wdata_nxt  = cyc_wdata;
          rmw_wr_nxt = 1'b0;
        end
      end
      BMWA_BUS_S0:   bus_nxt = BMWA_BUS_S1;
      BMWA_BUS_S1:   bus_nxt = BMWA_BUS_ADDR;
      BMWA_BUS_ADDR: bus_nxt = BMWA_BUS_DATA;
      BMWA_BUS_DATA: begin
        if (fault_s) begin
          bus_nxt = BMWA_BUS_END;
        end else if (transfer_acknowledge_s) begin
          if (!wr_r) begin
            rdata_nxt = data_in;
          end
          // R03 write back held strobe
          if (rmw_r && !rmw_wr_r) begin
            bus_nxt = BMWA_BUS_RMW_GAP;
          end else begin
            bus_nxt = BMWA_BUS_END;
          end
        end
      end
      BMWA_BUS_RMW_GAP: begin
        // The read acknowledge must clear first, or it would end the write.
        if (cyc_start && cyc_write && !transfer_acknowledge_s) begin
          wdata_nxt  = cyc_wdata;
          wr_nxt     = 1'b1;
          rmw_wr_nxt = 1'b1;
          bus_nxt    = BMWA_BUS_DATA;
        end
      end
      BMWA_BUS_END: begin
        done_nxt = 1'b1;
        bus_nxt  = BMWA_BUS_IDLE;
      end
      default: bus_nxt = BMWA_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bus_r    <= BMWA_BUS_IDLE;
      wr_r     <= BMWA_RST_OFF;
      word_r   <= BMWA_RST_OFF;
      sel_r    <= BMWA_RST_OFF;
      rmw_r    <= BMWA_RST_OFF;
      rmw_wr_r <= BMWA_RST_OFF;
      wdata_r  <= 16'h0000;
      rdata_r  <= 16'h0000;
      done_r   <= BMWA_RST_OFF;
    end else begin
      bus_r    <= bus_nxt;
      wr_r     <= wr_nxt;
      word_r   <= word_nxt;
      sel_r    <= sel_nxt;
      rmw_r    <= rmw_nxt;
      rmw_wr_r <= rmw_wr_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      done_r   <= done_nxt;
    end
  end

  // R05 R06 arbitration runs alongside transfers
  always_comb begin
    arb_nxt      = arb_r;
    gnt_nxt      = gnt_r;
    tri_nxt      = tri_r;
    cnt_nxt      = cnt_r;
    // R19 hold in S0 S1
    if (bus_r != BMWA_BUS_S0 && bus_r != BMWA_BUS_S1) begin
      // R17 outputs update on edge
      case (arb_r)
        BMWA_ARB_OWN: begin
          if (req_s && bus_r == BMWA_BUS_ADDR) begin
            // R09 delay one edge
            arb_nxt = BMWA_ARB_WAIT_S0;
          end else if (req_s) begin
            // R08 grant at once
            gnt_nxt = 1'b1;
            arb_nxt = BMWA_ARB_GRANT;
          end
        end
        BMWA_ARB_WAIT_S0: begin
          gnt_nxt = 1'b1;
          arb_nxt = BMWA_ARB_GRANT;
        end
        BMWA_ARB_GRANT: begin
          if (ack_s) begin
            // R12 acknowledge owns bus
            tri_nxt = 1'b1;
            cnt_nxt = BMWA_GNT_NEG_DLY;
            arb_nxt = BMWA_ARB_ACKED;
          end else if (!req_s) begin
            // R07 resume on withdraw
            gnt_nxt = 1'b0;
            arb_nxt = BMWA_ARB_OWN;
          end
        end
        BMWA_ARB_ACKED: begin
          // R14 R21 negate after delay
          if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
          end else begin
            gnt_nxt = 1'b0;
            cnt_nxt = BMWA_GNT_REA_DLY;
            arb_nxt = BMWA_ARB_NEG_WAIT;
          end
        end
        BMWA_ARB_NEG_WAIT: begin
          if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
          end else if (req_s) begin
            // R14 R21 reassert pending
            gnt_nxt = 1'b1;
            arb_nxt = BMWA_ARB_REASSERT;
          end else if (!ack_s) begin
            tri_nxt = 1'b0;
            arb_nxt = BMWA_ARB_OWN;
          end
        end
        BMWA_ARB_REASSERT: begin
          if (!ack_s) begin
            arb_nxt = BMWA_ARB_GRANT;
            tri_nxt = 1'b0;
          end
        end
        default: arb_nxt = BMWA_ARB_OWN;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      arb_r      <= BMWA_ARB_OWN;
      gnt_r      <= BMWA_RST_OFF;
      tri_r      <= BMWA_RST_OFF;
      cnt_r      <= 4'h0;
    end else begin
      arb_r      <= arb_nxt;
      gnt_r      <= gnt_nxt;
      tri_r      <= tri_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  logic in_cyc;
  logic [1:0] ln;
  assign in_cyc = (bus_r == BMWA_BUS_ADDR) || (bus_r == BMWA_BUS_DATA)
                  || (bus_r == BMWA_BUS_RMW_GAP);
  assign ln = lanes(word_r, sel_r);

  // R03 strobe held through
  assign addr_valid_strobe = in_cyc;
  assign upper_byte_strobe = (bus_r == BMWA_BUS_DATA) && ln[1];
  assign lower_byte_strobe = (bus_r == BMWA_BUS_DATA) && ln[0];
  assign write_not_read    = wr_r;
  assign data_out          = wdata_r;
  assign data_oe           = wr_r && in_cyc;
  // R18 float when released
  assign ctrl_oe           = !(tri_r && !in_cyc);
  assign mastership_grant  = gnt_r;
  assign cyc_done          = done_r;
  assign cyc_rdata         = rdata_r;

endmodule : bmwa_top
